// File: verilog/pbmr_pkg.sv
// Operation
// - speed select bit is read-only and always reports 100 Mbit/s.
// - auto-negotiation enable bit always reads zero.
// - power-down bit powers the PHY down; only register access keeps working.
// - power-down is control bit OR low pin input; asserted pin sets the bit.
// - isolate bit disconnects the MAC-side interface; management stays alive.
// - duplex bit is read-only, reset value one, meaning full duplex.
// - legacy capability bits in basic status all read zero.
// - frames without preamble are accepted and this ability reads one.
// - auto-negotiation complete reads one; auto-negotiation ability reads zero.
// - jabber and remote fault bits set by hardware on detection, reset zero.
// - link status bit reads one while link up, zero while down.
// - extended capability bit is read-only and reads one.
// - identifier words hold organisation id, model and revision fields.
// - receive error latch sets when error count nonzero; cleared by reading.
// - channel ok and descrambler lock latch low until the register is written.
// - interrupt pin status shows pin asserted; cleared by reading address 0x12.
// - phy status mirrors jabber, loopback, duplex (reset one) and link.
// - top bit of phy specific control disables the 125 MHz clock output.
// - power save mode 1 powers down blocks, PLL too when bit 11 zero.
// - SGMII soft reset bit resets SGMII logic then clears itself.
// - address-zero isolate option isolates MAC when latched address is zero.
// - transmit FIFO depth field selects 4, 5, 6 or 8 nibbles.
// - shared pin is power-down input when enable is 0, interrupt output when 1.
package pbmr_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [4:0]  ADDR_BASIC_CONTROL = 5'h00;
  localparam logic [4:0]  ADDR_BASIC_STATUS  = 5'h01;
  localparam logic [4:0]  ADDR_ID_HIGH       = 5'h02;
  localparam logic [4:0]  ADDR_ID_LOW        = 5'h03;
  localparam logic [4:0]  ADDR_PHY_STATUS    = 5'h10;
  localparam logic [4:0]  ADDR_PHY_SPEC_CTRL = 5'h11;
  localparam logic [4:0]  ADDR_INT_STATUS1   = 5'h12;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [15:0] RST_BASIC_CONTROL  = 16'h2100;
  localparam logic [15:0] RST_BASIC_STATUS   = 16'h0061;
  localparam logic [15:0] RST_PHY_STATUS     = 16'h0004;
  localparam logic [15:0] RST_PHY_SPEC_CTRL  = 16'h010B;
  // ----------------------------------------
  // basic control fields
  // ----------------------------------------
  localparam int          BC_SPEED           = 13;
  localparam int          BC_ANEG_EN         = 12;
  localparam int          BC_PWR_DOWN        = 11;
  localparam int          BC_ISOLATE         = 10;
  localparam int          BC_DUPLEX          = 8;
  // ----------------------------------------
  // basic status fields
  // ----------------------------------------
  localparam int          BS_PREAMBLE_SUP    = 6;
  localparam int          BS_ANEG_DONE       = 5;
  localparam int          BS_REMOTE_FAULT    = 4;
  localparam int          BS_LINK            = 2;
  localparam int          BS_JABBER          = 1;
  localparam int          BS_EXT_CAP         = 0;
  // ----------------------------------------
  // phy status fields
  // ----------------------------------------
  localparam int          PS_RX_ERR_LATCH    = 13;
  localparam int          PS_CHAN_OK         = 10;
  localparam int          PS_DESCR_LOCK      = 9;
  localparam int          PS_INT_PIN         = 7;
  localparam int          PS_JABBER          = 5;
  localparam int          PS_LOOPBACK        = 3;
  localparam int          PS_DUPLEX          = 2;
  localparam int          PS_LINK            = 0;
  // ----------------------------------------
  // phy specific control fields
  // ----------------------------------------
  localparam int          SC_DIS_REFCLK_125_OUTPUT      = 15;
  localparam int          SC_PSAVE_EN        = 14;
  localparam int          SC_PSAVE_HI        = 13;
  localparam int          SC_PSAVE_LO        = 12;
  localparam int          SC_SGMII_RST       = 11;
  localparam int          SC_AZ_ISOLATE      = 10;
  localparam int          SC_FIFO_HI         = 9;
  localparam int          SC_FIFO_LO         = 8;
  localparam int          SC_RSVD7           = 7;
  localparam int          SC_INT_POL         = 3;
  localparam int          SC_FORCE_INT       = 2;
  localparam int          SC_INT_EN          = 1;
  localparam int          SC_INT_OE          = 0;
  localparam logic [15:0] SC_WRITE_MASK      = 16'hFF8F;
  localparam logic [1:0]  PSAVE_IEEE_PD      = 2'h1;
  // ----------------------------------------
  // management frame codes
  // ----------------------------------------
  localparam logic [1:0]  OP_READ            = 2'h2;
  localparam logic [1:0]  OP_WRITE           = 2'h1;
  localparam logic [3:0]  FIELD5_LAST        = 4'h4;
  localparam logic [3:0]  DATA_LAST          = 4'hF;
  // ----------------------------------------
  // identification (values arbitrary)
  // ----------------------------------------
  localparam logic [21:0] OUI_DEFAULT        = 22'h0ABCDE;
  localparam logic [5:0]  MODEL_DEFAULT      = 6'h15;
  localparam logic [3:0]  REV_DEFAULT        = 4'h3;

  typedef enum logic [6:0] {
    PBMR_IDLE  = 7'h01,
    PBMR_START = 7'h02,
    PBMR_OP    = 7'h04,
    PBMR_PHY   = 7'h08,
    PBMR_REG   = 7'h10,
    PBMR_TA    = 7'h20,
    PBMR_DATA  = 7'h40
  } pbmr_state_e;
endpackage : pbmr_pkg

// File: verilog/pbmr_mdio_engine.sv
`timescale 1ns/1ns
module pbmr_mdio_engine (
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  // management pins
  input  wire logic        mdc_i,
  input  wire logic        mdio_i,
  output logic             mdio_o,
  output logic             mdio_oe_o,
  // register side
  input  wire logic [4:0]  phy_addr_i,
  input  wire logic [15:0] rd_data_i,
  output logic             rd_pulse_o,
  output logic             wr_pulse_o,
  output logic [4:0]       reg_addr_o,
  output logic [15:0]      wr_data_o
);
  pbmr_pkg::pbmr_state_e state_r;
  logic        mdc_d_r;
  logic        rise;
  logic [3:0]  cnt_r;
  logic [1:0]  op_r;
  logic [4:0]  phy_r;
  logic [15:0] shift_r;
  logic        match;

  assign rise  = mdc_i & ~mdc_d_r;
  assign match = (phy_r == phy_addr_i);

  always_ff @(posedge mclk_i) begin
    if (rst_i) mdc_d_r <= 1'b1;
    else       mdc_d_r <= mdc_i;
  end

  // ----------------------------------------
  // frame sequencer
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_r    <= pbmr_pkg::PBMR_IDLE;
      cnt_r      <= 4'h0;
      op_r       <= 2'h0;
      phy_r      <= 5'h00;
      reg_addr_o <= 5'h00;
      shift_r    <= 16'h0000;
      wr_data_o  <= 16'h0000;
      rd_pulse_o <= 1'b0;
      wr_pulse_o <= 1'b0;
      mdio_o     <= 1'b1;
      mdio_oe_o  <= 1'b0;
    end else begin
      rd_pulse_o <= 1'b0;
      wr_pulse_o <= 1'b0;
      if (rd_pulse_o) shift_r <= rd_data_i;
      if (rise) begin
        case (state_r)
          // no preamble needed: any 0 after idle starts a frame
          pbmr_pkg::PBMR_IDLE: begin
            if (!mdio_i) state_r <= pbmr_pkg::PBMR_START;
          end
          pbmr_pkg::PBMR_START: begin
            cnt_r   <= 4'h0;
            state_r <= mdio_i ? pbmr_pkg::PBMR_OP : pbmr_pkg::PBMR_IDLE;
          end
          pbmr_pkg::PBMR_OP: begin
            op_r  <= {op_r[0], mdio_i};
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == 4'h1) begin
              cnt_r   <= 4'h0;
              state_r <= pbmr_pkg::PBMR_PHY;
            end
          end
          pbmr_pkg::PBMR_PHY: begin
            phy_r <= {phy_r[3:0], mdio_i};
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == pbmr_pkg::FIELD5_LAST) begin
              cnt_r   <= 4'h0;
              state_r <= pbmr_pkg::PBMR_REG;
            end
          end
          pbmr_pkg::PBMR_REG: begin
            reg_addr_o <= {reg_addr_o[3:0], mdio_i};
            cnt_r      <= cnt_r + 4'h1;
            if (cnt_r == pbmr_pkg::FIELD5_LAST) begin
              cnt_r      <= 4'h0;
              rd_pulse_o <= (op_r == pbmr_pkg::OP_READ) && match;
              state_r    <= pbmr_pkg::PBMR_TA;
            end
          end
          pbmr_pkg::PBMR_TA: begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == 4'h0) begin
              mdio_oe_o <= (op_r == pbmr_pkg::OP_READ) && match;
              mdio_o    <= 1'b0;
            end else begin
              mdio_o  <= shift_r[15];
              shift_r <= {shift_r[14:0], 1'b0};
              cnt_r   <= 4'h0;
              state_r <= pbmr_pkg::PBMR_DATA;
            end
          end
          pbmr_pkg::PBMR_DATA: begin
            cnt_r <= cnt_r + 4'h1;
            if (mdio_oe_o) begin
              mdio_o  <= shift_r[15];
              shift_r <= {shift_r[14:0], 1'b0};
            end else begin
              shift_r <= {shift_r[14:0], mdio_i};
            end
            if (cnt_r == pbmr_pkg::DATA_LAST) begin
              mdio_oe_o  <= 1'b0;
              mdio_o     <= 1'b1;
              wr_pulse_o <= (op_r == pbmr_pkg::OP_WRITE) && match;
              wr_data_o  <= {shift_r[14:0], mdio_i};
              state_r    <= pbmr_pkg::PBMR_IDLE;
            end
          end
          default: state_r <= pbmr_pkg::PBMR_IDLE;
        endcase
      end
    end
  end
endmodule : pbmr_mdio_engine

// File: verilog/pbmr_top.sv
`timescale 1ns/1ns
module pbmr_top (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  // management pins
  input  wire logic       mdc_i,
  input  wire logic       mdio_i,
  output logic            mdio_o,
  output logic            mdio_oe_o,
  // straps
  input  wire logic [4:0] phy_addr_strap_i,
  // shared interrupt / power-down pin
  input  wire logic       int_pin_i,
  output logic            int_pin_o,
  output logic            int_pin_oe_o,
  // core status
  input  wire logic       link_up_i,
  input  wire logic       jabber_i,
  input  wire logic       remote_fault_i,
  input  wire logic       rx_fault_count_nonzero_i,
  input  wire logic       channel_ok_i,
  input  wire logic       descr_lock_i,
  input  wire logic       loopback_i,
  input  wire logic       int_req_i,
  // core control
  output logic            power_down_o,
  output logic            pll_off_o,
  output logic            isolate_o,
  output logic            refclk_125_output_en_o,
  output logic            sgmii_reset_o,
  output logic [3:0]      tx_fifo_depth_o
);
  parameter logic [21:0] OUI   = pbmr_pkg::OUI_DEFAULT;
  parameter logic [5:0]  MODEL = pbmr_pkg::MODEL_DEFAULT;
  parameter logic [3:0]  REV   = pbmr_pkg::REV_DEFAULT;

  logic        rd_pulse;
  logic        wr_pulse;
  logic [4:0]  reg_addr;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic [4:0]  phy_addr_r;
  logic        pwr_down_r;
  logic        isolate_r;
  logic        jabber_r;
  logic        rfault_r;
  logic        rx_err_r;
  logic        chan_ok_r;
  logic        descr_lock_r;
  logic        int_pin_r;
  logic [15:0] spec_ctrl_r;
  logic        wr_bc;
  logic        wr_ps;
  logic        wr_sc;
  logic        rd_bs;
  logic        rd_ps;
  logic        pin_pd;
  logic        int_active;
  logic        ieee_pd;
  logic        pd_eff;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [3:0] fifo_nibbles(input logic [1:0] code);
    case (code)
      2'h0:    fifo_nibbles = 4'h4;
      2'h1:    fifo_nibbles = 4'h5;
      2'h2:    fifo_nibbles = 4'h6;
      default: fifo_nibbles = 4'h8;
    endcase
  endfunction : fifo_nibbles

  function automatic logic [15:0] basic_control_word(input logic pd, input logic iso);
    basic_control_word                         = 16'h0000;
    basic_control_word[pbmr_pkg::BC_SPEED]     = 1'b1;
    basic_control_word[pbmr_pkg::BC_ANEG_EN]   = 1'b0;
    basic_control_word[pbmr_pkg::BC_PWR_DOWN]  = pd;
    basic_control_word[pbmr_pkg::BC_ISOLATE]   = iso;
    basic_control_word[pbmr_pkg::BC_DUPLEX]    = 1'b1;
  endfunction : basic_control_word

  // ----------------------------------------
  // management frame engine
  // ----------------------------------------
  pbmr_mdio_engine u_engine (
    .mclk_i     (mclk_i),
    .rst_i      (rst_i),
    .mdc_i      (mdc_i),
    .mdio_i     (mdio_i),
    .mdio_o     (mdio_o),
    .mdio_oe_o  (mdio_oe_o),
    .phy_addr_i (phy_addr_r),
    .rd_data_i  (rd_data),
    .rd_pulse_o (rd_pulse),
    .wr_pulse_o (wr_pulse),
    .reg_addr_o (reg_addr),
    .wr_data_o  (wr_data)
  );

  assign wr_bc      = wr_pulse && (reg_addr == pbmr_pkg::ADDR_BASIC_CONTROL);
  assign wr_ps      = wr_pulse && (reg_addr == pbmr_pkg::ADDR_PHY_STATUS);
  assign wr_sc      = wr_pulse && (reg_addr == pbmr_pkg::ADDR_PHY_SPEC_CTRL);
  assign rd_bs      = rd_pulse && (reg_addr == pbmr_pkg::ADDR_BASIC_STATUS);
  assign rd_ps      = rd_pulse && (reg_addr == pbmr_pkg::ADDR_PHY_STATUS);
  assign pin_pd     = !spec_ctrl_r[pbmr_pkg::SC_INT_OE] && !int_pin_i;
  assign int_active = spec_ctrl_r[pbmr_pkg::SC_FORCE_INT]
                    | (spec_ctrl_r[pbmr_pkg::SC_INT_EN] & int_req_i);
  assign ieee_pd    = spec_ctrl_r[pbmr_pkg::SC_PSAVE_EN]
                    && (spec_ctrl_r[pbmr_pkg::SC_PSAVE_HI:pbmr_pkg::SC_PSAVE_LO]
                        == pbmr_pkg::PSAVE_IEEE_PD);
  assign pd_eff     = pwr_down_r | pin_pd | ieee_pd;

  // ----------------------------------------
  // address strap
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) phy_addr_r <= phy_addr_strap_i;
  end

  // ----------------------------------------
  // basic control
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pwr_down_r <= pbmr_pkg::RST_BASIC_CONTROL[pbmr_pkg::BC_PWR_DOWN];
      isolate_r  <= pbmr_pkg::RST_BASIC_CONTROL[pbmr_pkg::BC_ISOLATE];
    end else begin
      if (wr_bc) begin
        pwr_down_r <= wr_data[pbmr_pkg::BC_PWR_DOWN];
        isolate_r  <= wr_data[pbmr_pkg::BC_ISOLATE];
      end
      if (pin_pd) pwr_down_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // basic status latches
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      jabber_r <= 1'b0;
      rfault_r <= 1'b0;
    end else begin
      if (rd_bs) begin
        jabber_r <= 1'b0;
        rfault_r <= 1'b0;
      end
      if (jabber_i)       jabber_r <= 1'b1;
      if (remote_fault_i) rfault_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // phy status latches
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rx_err_r     <= pbmr_pkg::RST_PHY_STATUS[pbmr_pkg::PS_RX_ERR_LATCH];
      chan_ok_r    <= pbmr_pkg::RST_PHY_STATUS[pbmr_pkg::PS_CHAN_OK];
      descr_lock_r <= pbmr_pkg::RST_PHY_STATUS[pbmr_pkg::PS_DESCR_LOCK];
      int_pin_r    <= pbmr_pkg::RST_PHY_STATUS[pbmr_pkg::PS_INT_PIN];
    end else begin
      if (rd_ps)                    rx_err_r <= 1'b0;
      if (rx_fault_count_nonzero_i) rx_err_r <= 1'b1;
      if (wr_ps) begin
        chan_ok_r    <= channel_ok_i;
        descr_lock_r <= descr_lock_i;
      end
      if (!channel_ok_i) chan_ok_r    <= 1'b0;
      if (!descr_lock_i) descr_lock_r <= 1'b0;
      if (rd_pulse && (reg_addr == pbmr_pkg::ADDR_INT_STATUS1)) int_pin_r <= 1'b0;
      if (int_active && spec_ctrl_r[pbmr_pkg::SC_INT_OE]) int_pin_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // phy specific control
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      spec_ctrl_r <= pbmr_pkg::RST_PHY_SPEC_CTRL;
    end else begin
      spec_ctrl_r[pbmr_pkg::SC_SGMII_RST] <= 1'b0;
      if (wr_sc) spec_ctrl_r <= wr_data & pbmr_pkg::SC_WRITE_MASK;
    end
  end

  // ----------------------------------------
  // read data mux
  // ----------------------------------------
  always_comb begin
    rd_data = 16'h0000;
    case (reg_addr)
      pbmr_pkg::ADDR_BASIC_CONTROL: rd_data = basic_control_word(pwr_down_r, isolate_r);
      pbmr_pkg::ADDR_BASIC_STATUS: begin
        rd_data[pbmr_pkg::BS_PREAMBLE_SUP] = 1'b1;
        rd_data[pbmr_pkg::BS_ANEG_DONE]    = 1'b1;
        rd_data[pbmr_pkg::BS_REMOTE_FAULT] = rfault_r;
        rd_data[pbmr_pkg::BS_LINK]         = link_up_i;
        rd_data[pbmr_pkg::BS_JABBER]       = jabber_r;
        rd_data[pbmr_pkg::BS_EXT_CAP]      = 1'b1;
      end
      pbmr_pkg::ADDR_ID_HIGH: rd_data = OUI[21:6];
      pbmr_pkg::ADDR_ID_LOW:  rd_data = {OUI[5:0], MODEL, REV};
      pbmr_pkg::ADDR_PHY_STATUS: begin
        rd_data[pbmr_pkg::PS_RX_ERR_LATCH] = rx_err_r;
        rd_data[pbmr_pkg::PS_CHAN_OK]      = chan_ok_r;
        rd_data[pbmr_pkg::PS_DESCR_LOCK]   = descr_lock_r;
        rd_data[pbmr_pkg::PS_INT_PIN]      = int_pin_r;
        rd_data[pbmr_pkg::PS_JABBER]       = jabber_r;
        rd_data[pbmr_pkg::PS_LOOPBACK]     = loopback_i;
        rd_data[pbmr_pkg::PS_DUPLEX]       = 1'b1;
        rd_data[pbmr_pkg::PS_LINK]         = link_up_i;
      end
      pbmr_pkg::ADDR_PHY_SPEC_CTRL: rd_data = spec_ctrl_r;
      default: rd_data = 16'h0000;
    endcase
  end

  // ----------------------------------------
  // core control outputs
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      power_down_o           <= 1'b0;
      pll_off_o              <= 1'b0;
      isolate_o              <= 1'b0;
      refclk_125_output_en_o <= 1'b0;
      sgmii_reset_o          <= 1'b0;
      tx_fifo_depth_o        <= 4'h5;
    end else begin
      power_down_o           <= pd_eff;
      pll_off_o              <= ieee_pd && !spec_ctrl_r[pbmr_pkg::SC_SGMII_RST];
      isolate_o              <= isolate_r || pd_eff
                              || (spec_ctrl_r[pbmr_pkg::SC_AZ_ISOLATE]
                                  && (phy_addr_r == 5'h00));
      refclk_125_output_en_o <= !spec_ctrl_r[pbmr_pkg::SC_DIS_REFCLK_125_OUTPUT] && !pd_eff;
      sgmii_reset_o          <= spec_ctrl_r[pbmr_pkg::SC_SGMII_RST];
      tx_fifo_depth_o        <= fifo_nibbles(
                                  spec_ctrl_r[pbmr_pkg::SC_FIFO_HI:pbmr_pkg::SC_FIFO_LO]);
    end
  end

  // ----------------------------------------
  // shared pin driver
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      int_pin_o    <= 1'b1;
      int_pin_oe_o <= 1'b0;
    end else begin
      int_pin_o    <= spec_ctrl_r[pbmr_pkg::SC_INT_POL] ? !int_active : int_active;
      int_pin_oe_o <= spec_ctrl_r[pbmr_pkg::SC_INT_OE];
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  ro_control_a: assert property (
    rd_pulse && (reg_addr == pbmr_pkg::ADDR_BASIC_CONTROL)
    |-> rd_data[pbmr_pkg::BC_SPEED] && !rd_data[pbmr_pkg::BC_ANEG_EN]
        && rd_data[pbmr_pkg::BC_DUPLEX])
    else $error("read-only control bits changed");

  pin_powerdown_a: assert property (pin_pd |=> pwr_down_r ##1 power_down_o)
    else $error("power-down pin did not set the bit");
  pd_output_a: assert property (pwr_down_r |=> power_down_o && isolate_o)
    else $error("power-down not reflected on outputs");
  isolate_out_a: assert property (wr_bc && wr_data[pbmr_pkg::BC_ISOLATE]
    |=> ##1 isolate_o)
    else $error("isolate write not reflected");
  rx_latch_a: assert property (rx_fault_count_nonzero_i |=> rx_err_r)
    else $error("receive error latch missed event");
  rx_clear_a: assert property (rd_ps && !rx_fault_count_nonzero_i |=> !rx_err_r)
    else $error("receive error latch not cleared by read");
  latch_low_a: assert property (!channel_ok_i && !wr_ps |=> !chan_ok_r)
    else $error("channel ok latch did not drop");
  soft_reset_a: assert property (wr_sc && wr_data[pbmr_pkg::SC_SGMII_RST]
    |=> sgmii_reset_o == 1'b0 ##1 sgmii_reset_o ##1 !sgmii_reset_o)
    else $error("soft reset did not self clear");
  az_isolate_a: assert property ($past(spec_ctrl_r[pbmr_pkg::SC_AZ_ISOLATE])
    && phy_addr_r == 5'h00 |-> isolate_o)
    else $error("address zero isolate failed");
  fifo_depth_a: assert property (
    $past(spec_ctrl_r[pbmr_pkg::SC_FIFO_HI:pbmr_pkg::SC_FIFO_LO]) == 2'h3
    |-> tx_fifo_depth_o == 4'h8)
    else $error("fifo depth decode wrong");
  int_status_a: assert property (int_active && spec_ctrl_r[pbmr_pkg::SC_INT_OE] |=> int_pin_r)
    else $error("interrupt pin status not set");

  read_seen_c: cover property (rd_ps ##[1:100] rd_bs);
  write_seen_c: cover property (wr_sc ##1 sgmii_reset_o);
  pin_pd_c: cover property (pin_pd ##2 power_down_o);
endmodule : pbmr_top

// File: test/pbmr_mgmt_model.sv
`timescale 1ns/1ns
module pbmr_mgmt_model (
  // clock
  input  wire logic mclk_i,
  // device drive of the data line
  input  wire logic mdio_o,
  input  wire logic mdio_oe_o,
  // controller pins
  output logic      mdc_o,
  output logic      mdio_w_o
);
  logic drv_r = 1'b0;
  logic bit_r = 1'b1;
  int   hp    = 2;
  // pull-up holds the line when nobody drives
  assign mdio_w_o = mdio_oe_o ? mdio_o : (drv_r ? bit_r : 1'b1);
  initial mdc_o = 1'b0;
  // frame with no preamble, mdc parked low afterwards
  task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] q);
    logic [31:0] f;
    logic [31:0] r;
    f = {2'b01, rd, !rd, pa, ra, 2'b10, wd};
    r = 32'h0;
    for (int i = 0; i < 32; i++) begin
      mdc_o = 1'b0;
      drv_r = !(rd && i > 13);
      bit_r = f[31-i];
      repeat (hp) @(posedge mclk_i);
      #1 r = {r[30:0], mdio_w_o};
      mdc_o = 1'b1;
      repeat (hp) @(posedge mclk_i);
      #1;
    end
    mdc_o = 1'b0;
    drv_r = 1'b0;
    q = r[15:0];
  endtask : frame
endmodule : pbmr_mgmt_model

// File: test/phy_basic_mgmt_registers_tb.sv
`timescale 1ns/1ns
module phy_basic_mgmt_registers_tb;
  logic        mclk_i = 1'b0;
  logic        rst_i  = 1'b1;
  logic        mdc;
  logic        mdio_w;
  logic        mdio_o;
  logic        mdio_oe_o;
  logic        pin    = 1'b1;
  logic        int_pin_o;
  logic        int_pin_oe_o;
  logic [2:0]  ev     = 3'h0;
  logic [3:0]  lv     = 4'h0;
  logic [4:0]  strap  = 5'h00;
  logic        power_down_o;
  logic        pll_off_o;
  logic        isolate_o;
  logic        refclk_125_output_en_o;
  logic        sgmii_reset_o;
  logic [3:0]  tx_fifo_depth_o;
  logic [15:0] d;
  int          fails, num_checks, cycles, n_sr;
  logic [3:0]  dep [4] = '{4'h4, 4'h5, 4'h6, 4'h8};
  logic [20:0] rows [7] = '{{5'h00, 16'h2100}, {5'h01, 16'h0061}, {5'h05, 16'h0000},
    {5'h02, pbmr_pkg::OUI_DEFAULT[21:6]}, {5'h10, 16'h0004}, {5'h11, 16'h010B},
    {5'h03, pbmr_pkg::OUI_DEFAULT[5:0], pbmr_pkg::MODEL_DEFAULT, pbmr_pkg::REV_DEFAULT}};
  pbmr_top u_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .mdc_i(mdc), .mdio_i(mdio_w), .mdio_o(mdio_o),
    .mdio_oe_o(mdio_oe_o), .phy_addr_strap_i(strap),
    .int_pin_i(int_pin_oe_o ? int_pin_o : pin), .int_pin_o(int_pin_o),
    .int_pin_oe_o(int_pin_oe_o), .link_up_i(lv[0]), .jabber_i(ev[0]),
    .remote_fault_i(ev[1]), .rx_fault_count_nonzero_i(ev[2]), .channel_ok_i(lv[1]),
    .descr_lock_i(lv[2]), .loopback_i(lv[3]), .int_req_i(1'b0),
    .power_down_o(power_down_o), .pll_off_o(pll_off_o), .isolate_o(isolate_o),
    .refclk_125_output_en_o(refclk_125_output_en_o), .sgmii_reset_o(sgmii_reset_o),
    .tx_fifo_depth_o(tx_fifo_depth_o));
  pbmr_mgmt_model u_mgmt (.mclk_i(mclk_i), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o),
                          .mdc_o(mdc), .mdio_w_o(mdio_w));
  initial forever #20 mclk_i = !mclk_i;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [4:0] a, input logic [15:0] e);
    logic [15:0] q;
    u_mgmt.frame(1'b1, strap, a, 16'h0000, q);
    chk(q, e);
  endtask : rchk
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    logic [15:0] q;
    u_mgmt.frame(1'b0, strap, a, v, q);
    repeat (3) @(posedge mclk_i);
    #1;
  endtask : wr
  task automatic final_report;
    if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  always @(posedge mclk_i) begin
    cycles++;
    if (sgmii_reset_o === 1'b1) n_sr++;
    if (cycles == 30000) begin
      fails++;
      final_report;
    end
  end
  initial begin
    repeat (3) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    #1 chk({power_down_o, tx_fifo_depth_o}, 16'h0005);
    foreach (rows[i]) rchk(rows[i][20:16], rows[i][15:0]);
    wr(5'h00, 16'hFFFF);
    chk({power_down_o, isolate_o}, 16'h0003);
    rchk(5'h00, 16'h2D00);
    wr(5'h00, 16'h0000);
    lv = 4'h7;
    ev = 3'h7;
    @(posedge mclk_i) #1 ev = 3'h0;
    rchk(5'h01, 16'h0077);
    rchk(5'h01, 16'h0065);
    wr(5'h10, 16'h0000);
    rchk(5'h10, 16'h2605);
    rchk(5'h10, 16'h0605);
    lv = 4'h5;
    rchk(5'h10, 16'h0205);
    lv = 4'hD;
    rchk(5'h10, 16'h020D);
    lv = 4'h5;
    for (int c = 0; c < 4; c++) begin
      wr(5'h11, {6'h00, c[1:0], 8'h0B});
      chk(tx_fifo_depth_o, dep[c]);
    end
    wr(5'h11, 16'h8D0F);
    chk({refclk_125_output_en_o, isolate_o, int_pin_o, int_pin_oe_o}, 16'h0005);
    chk(16'(n_sr), 16'h0001);
    rchk(5'h11, 16'h850F);
    rchk(5'h10, 16'h0285);
    wr(5'h11, 16'h010B);
    rchk(5'h12, 16'h0000);
    rchk(5'h10, 16'h0205);
    wr(5'h11, 16'h510B);
    chk(power_down_o, 16'h0001);
    chk(pll_off_o, 16'h0001);
    wr(5'h11, 16'h010A);
    pin = 1'b0;
    repeat (3) @(posedge mclk_i);
    #1 chk({power_down_o, int_pin_oe_o}, 16'h0002);
    pin = 1'b1;
    rchk(5'h00, 16'h2900);
    strap = 5'h01;
    rst_i = 1'b1;
    repeat (3) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    rchk(5'h00, 16'h2100);
    chk(refclk_125_output_en_o, 16'h0001);
    wr(5'h11, 16'h050B);
    chk(isolate_o, 16'h0000);
    u_mgmt.hp = 3;
    u_mgmt.frame(1'b1, 5'h00, 5'h11, 16'h0000, d);
    chk(d, 16'hFFFF);
    final_report;
  end
endmodule : phy_basic_mgmt_registers_tb
